// File: rtl/smr_pkg.sv
// shared constants, types and helpers of the serial message recognizer
package smr_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int unsigned TICK_W = 16;
   localparam int unsigned HOLD_BYTES = 128;
   localparam int unsigned HOLD_AW = 7;
   localparam int unsigned SEP_BYTES = 8;
   localparam int unsigned CAP_BYTES = 12;
   localparam logic [7:0] HOLD_MAX = 8'h80;
   localparam logic [3:0] CAP_MAX = 4'hC;
   localparam logic [3:0] SEP_MAX = 4'h8;
   localparam logic [7:0] FLEET_RST_MS = 8'h32;
   localparam logic [15:0] IDLE_MIN_MS = 16'h000A;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_SEP_LO = 12'h004;
   localparam logic [11:0] OFS_SEP_HI = 12'h008;
   localparam logic [11:0] OFS_SEP_LEN = 12'h00C;
   localparam logic [11:0] OFS_IDLE = 12'h010;
   localparam logic [11:0] OFS_FLEET_T = 12'h014;
   localparam logic [11:0] OFS_ACTION = 12'h018;
   localparam logic [11:0] OFS_STAT = 12'h01C;
   localparam logic [11:0] OFS_MASK = 12'h020;
   localparam logic [11:0] OFS_LAST_LEN = 12'h028;
   localparam logic [11:0] OFS_FLEET_LEN = 12'h02C;
   localparam logic [11:0] OFS_DIGEST = 12'h030;
   localparam logic [11:0] OFS_LAST_TXT = 12'h040;
   localparam logic [11:0] OFS_LAST_HEX = 12'h050;
   localparam logic [11:0] OFS_FLEET_TXT = 12'h070;
   localparam logic [11:0] OFS_FLEET_HEX = 12'h080;
   localparam logic [11:0] OFS_TX_RAW = 12'h0A0;
   localparam logic [11:0] OFS_TX_TEXT = 12'h0A4;
   localparam logic [11:0] OFS_STATUS = 12'h0A8;
   localparam logic [11:0] OFS_HOLD = 12'h100;
   localparam logic [11:0] TXT_SPAN = 12'h00C;
   localparam logic [11:0] HEX_SPAN = 12'h018;
   localparam logic [11:0] HOLD_SPAN = 12'h200;
   // field positions, status width and ascii character codes
   localparam int unsigned CTRL_ON_FIRST = 0;
   localparam int unsigned CTRL_ON_SECOND = 1;
   localparam int unsigned CTRL_CLEAR = 8;
   localparam int unsigned ST_RECOG = 0;
   localparam int unsigned ST_PERS = 1;
   localparam int unsigned ST_FLEET = 2;
   localparam int unsigned ST_OVFL = 3;
   localparam int unsigned STAT_W = 4;
   localparam logic [7:0] CH_BSLASH = 8'h5C;
   localparam logic [7:0] CH_X = 8'h78;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_UA = 8'h41;
   localparam logic [7:0] CH_UF = 8'h46;
   localparam logic [7:0] CH_LA = 8'h61;
   localparam logic [7:0] CH_LF = 8'h66;
   localparam logic [7:0] HEX_TEN = 8'h0A;

   typedef enum logic [1:0] {ESC_IDLE, ESC_SLASH, ESC_X, ESC_HI} smr_esc_e;
   typedef struct packed {logic valid; logic [7:0] data;} smr_rx_s;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } smr_apb_s;
   typedef struct packed {logic fire; logic [7:0] number;} smr_action_s;

   // {ok, nibble} from an ascii hex digit
   function automatic logic [4:0] smr_from_hex(input logic [7:0] c);
      if (c >= CH_0 && c <= CH_9) return {1'b1, 4'(c - CH_0)};
      if (c >= CH_UA && c <= CH_UF) return {1'b1, 4'(c - CH_UA + HEX_TEN)};
      if (c >= CH_LA && c <= CH_LF) return {1'b1, 4'(c - CH_LA + HEX_TEN)};
      return 5'h00;
   endfunction

   function automatic logic [7:0] smr_to_hex(input logic [3:0] n);
      return (n < 4'hA) ? CH_0 + 8'(n) : CH_UA + 8'(n) - HEX_TEN;
   endfunction
endpackage

// File: rtl/smr_mem.sv
// holding memory for unrecognized bytes, registered read
`timescale 1ns/10ps
module smr_mem #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 128,
   parameter int unsigned AW = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   typedef struct packed {
      logic [D-1:0][W-1:0] m;
      logic [W-1:0] q;
   } smr_mem_s;
   smr_mem_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (we) begin
         s_d.m[waddr] = wdata;
      end
      s_d.q = s_q.m[raddr];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.q;
endmodule // smr_mem

// File: rtl/smr_recognizer.sv
// serial message recognizer with apb registers and a small transmit path
// Notes on behaviour
// - close and recognize the message when the separator pattern arrives.
// - also close it when the idle gap passes after the last byte.
// - hold unrecognized bytes, at most 128 of them.
// - held bytes publish to persistent and fleeting copies once closed.
// - separator is up to 8 bytes, i.e. up to 16 hex digits.
// - idle gap in ms; 0 disables it, nonzero values below 10 become 10.
// - persistent copy stays until the next message or a clear.
// - persistent text keeps at most 12 bytes.
// - each text copy is also readable as hex digit pairs.
// - a clear erases all stored messages.
// - fleeting copy loads with each message and empties after retention time.
// - retention time 0 to 255 ms, reset 50 ms, covers text, hex, digest.
// - change events when a copy's value changes; fleeting ones also on every expiry and every load into an empty copy.
// - each recognized message fires the linked action number unconditionally.
// - raw transmit takes hex digit pairs and sends each as one byte.
// - text transmit turns backslash x and two hex digits into one byte.
// - recognition enables exist per port, first and second serial port.
`timescale 1ns/10ps
module smr_recognizer #(
   parameter int unsigned MS_CYC = smr_pkg::MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input smr_pkg::smr_apb_s apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input smr_pkg::smr_rx_s rx_first,
   input smr_pkg::smr_rx_s rx_second,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   output smr_pkg::smr_action_s action,
   output logic irq
);
   import smr_pkg::*;

   typedef struct packed {
      logic [1:0] on;
      logic [SEP_BYTES*8-1:0] sep;
      logic [3:0] sep_len;
      logic [15:0] idle_ms;
      logic [7:0] fleet_ms;
      logic [7:0] act_num;
      logic [STAT_W-1:0] mask;
      logic [STAT_W-1:0] stat;
      logic [SEP_BYTES*8-1:0] tail;
      logic [7:0] hold_cnt;
      logic [CAP_BYTES*8-1:0] cap;
      logic [15:0] idle_cnt;
      logic [CAP_BYTES*8-1:0] last;
      logic [3:0] last_len;
      logic [CAP_BYTES*8-1:0] fl;
      logic [3:0] fl_len;
      logic [15:0] fl_dig;
      logic [7:0] fl_cnt;
      logic fl_live;
      logic [TICK_W-1:0] tick_cnt;
      smr_esc_e esc;
      logic [3:0] esc_nib;
      logic [7:0] tx_byte;
      logic tx_valid;
      logic [7:0] pend;
      logic pend_v;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic act_fire;
      logic [7:0] act_out;
      logic irq;
   } smr_st_s;

   smr_st_s q, d;
   logic [7:0] mem_rdata;
   logic mem_we;
   logic [HOLD_AW-1:0] mem_waddr;
   logic [7:0] mem_wdata;

   // text word k: byte 0 of the message in bits 7:0, bytes past len read zero
   function automatic logic [31:0] txt_word(input logic [CAP_BYTES*8-1:0] b, input logic [3:0] len,
                                            input logic [3:0] k);
      logic [31:0] w;
      w = '0;
      for (int i = 0; i < 4; i++) begin
         if (4'(k * 4 + i) < len) w[i*8 +: 8] = b[(k*4+i)*8 +: 8];
      end
      return w;
   endfunction

   // hex word k: two message bytes as four digit characters, first digit low
   function automatic logic [31:0] hex_word(input logic [CAP_BYTES*8-1:0] b, input logic [3:0] len,
                                            input logic [3:0] k);
      logic [31:0] w;
      logic [7:0] by;
      w = '0;
      by = '0;
      for (int i = 0; i < 2; i++) begin
         by = b[(k*2+i)*8 +: 8];
         if (4'(k * 2 + i) < len) begin
            w[i*16 +: 8] = smr_to_hex(by[7:4]);
            w[i*16+8 +: 8] = smr_to_hex(by[3:0]);
         end
      end
      return w;
   endfunction

   function automatic logic [15:0] digest(input logic [CAP_BYTES*8-1:0] b, input logic [3:0] len);
      logic [15:0] h;
      h = '0;
      for (int i = 0; i < CAP_BYTES; i++) begin
         if (4'(i) < len) h = {h[14:0], h[15]} ^ {8'h00, b[i*8 +: 8]};
      end
      return h;
   endfunction

   logic acc, done, wr, rd_clr, busy, byte_v, match, pub, tick, clr;
   logic [7:0] rbyte, cnt_n;
   logic [3:0] plen;
   logic [CAP_BYTES*8-1:0] pcap;
   logic [SEP_BYTES*8-1:0] tail_n;
   logic [STAT_W-1:0] ev;
   logic [11:0] a, off, hoff;
   logic [31:0] rd;
   logic [4:0] hx, hy;

   always_comb begin
      d = q;
      d.act_fire = 1'b0;
      ev = '0;
      clr = 1'b0;
      a = apb.paddr;
      off = '0;
      rd = '0;
      hx = '0;
      hy = '0;
      mem_we = 1'b0;
      mem_waddr = q.hold_cnt[HOLD_AW-1:0];
      mem_wdata = '0;
      // millisecond enable; long divide is a parameter so benches can shorten it
      tick = (q.tick_cnt == TICK_W'(MS_CYC - 1));
      d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;

      // apb: one wait state on every access so the hold memory can answer
      hoff = apb.paddr - OFS_HOLD;
      acc = apb.psel & apb.penable;
      done = acc & q.pready;
      wr = done & apb.pwrite;
      rd_clr = done & ~apb.pwrite & (a == OFS_STAT);
      d.pready = acc & ~q.pready;
      if (a == OFS_CTRL) rd = {30'h0, q.on};
      else if (a == OFS_SEP_LO) rd = q.sep[31:0];
      else if (a == OFS_SEP_HI) rd = q.sep[63:32];
      else if (a == OFS_SEP_LEN) rd = {28'h0, q.sep_len};
      else if (a == OFS_IDLE) rd = {16'h0, q.idle_ms};
      else if (a == OFS_FLEET_T) rd = {24'h0, q.fleet_ms};
      else if (a == OFS_ACTION) rd = {24'h0, q.act_num};
      else if (a == OFS_STAT) rd = {28'h0, q.stat};
      else if (a == OFS_MASK) rd = {28'h0, q.mask};
      else if (a == OFS_LAST_LEN) rd = {28'h0, q.last_len};
      else if (a == OFS_FLEET_LEN) rd = {28'h0, q.fl_len};
      else if (a == OFS_DIGEST) rd = {16'h0, q.fl_dig};
      else if (a == OFS_STATUS) rd = {16'h0, q.hold_cnt, 7'h00, q.tx_valid | q.pend_v};
      else if (a == OFS_TX_RAW || a == OFS_TX_TEXT) rd = '0;
      else if (a >= OFS_LAST_TXT && a < OFS_LAST_TXT + TXT_SPAN) begin
         off = a - OFS_LAST_TXT;
         rd = txt_word(q.last, q.last_len, off[5:2]);
      end else if (a >= OFS_LAST_HEX && a < OFS_LAST_HEX + HEX_SPAN) begin
         off = a - OFS_LAST_HEX;
         rd = hex_word(q.last, q.last_len, off[5:2]);
      end else if (a >= OFS_FLEET_TXT && a < OFS_FLEET_TXT + TXT_SPAN) begin
         off = a - OFS_FLEET_TXT;
         rd = txt_word(q.fl, q.fl_len, off[5:2]);
      end else if (a >= OFS_FLEET_HEX && a < OFS_FLEET_HEX + HEX_SPAN) begin
         off = a - OFS_FLEET_HEX;
         rd = hex_word(q.fl, q.fl_len, off[5:2]);
      end else if (a >= OFS_HOLD && a < OFS_HOLD + HOLD_SPAN) begin
         rd = {24'h0, mem_rdata};
      end else begin
         off = 12'hFFF;
      end
      if (acc & ~q.pready) begin
         d.prdata = apb.pwrite ? '0 : rd;
         d.pslverr = (off == 12'hFFF);
      end
      if (done) begin
         d.pslverr = 1'b0;
      end

      // busy transmit ignores new writes, software polls the status word
      busy = q.tx_valid | q.pend_v;
      if (q.tx_valid & tx_ready) begin
         d.tx_valid = q.pend_v;
         d.tx_byte = q.pend;
         d.pend_v = 1'b0;
      end

      if (wr) begin
         case (a)
            OFS_CTRL: begin
               d.on = apb.pwdata[CTRL_ON_SECOND:CTRL_ON_FIRST];
               clr = apb.pwdata[CTRL_CLEAR];
            end
            OFS_SEP_LO: d.sep[31:0] = apb.pwdata;
            OFS_SEP_HI: d.sep[63:32] = apb.pwdata;
            OFS_SEP_LEN: d.sep_len = (apb.pwdata[3:0] > SEP_MAX) ? SEP_MAX : apb.pwdata[3:0];
            OFS_IDLE: begin
               d.idle_ms = apb.pwdata[15:0];
               if (apb.pwdata[15:0] != '0 && apb.pwdata[15:0] < IDLE_MIN_MS) d.idle_ms = IDLE_MIN_MS;
            end
            OFS_FLEET_T: d.fleet_ms = apb.pwdata[7:0];
            OFS_ACTION: d.act_num = apb.pwdata[7:0];
            OFS_MASK: d.mask = apb.pwdata[STAT_W-1:0];
            OFS_TX_RAW: begin
               hx = smr_from_hex(apb.pwdata[15:8]);
               hy = smr_from_hex(apb.pwdata[7:0]);
               if (!busy && hx[4] && hy[4]) begin
                  d.tx_byte = {hx[3:0], hy[3:0]};
                  d.tx_valid = 1'b1;
               end
            end
            OFS_TX_TEXT: begin
               hx = smr_from_hex(apb.pwdata[7:0]);
               if (!busy) begin
                  case (q.esc)
                     ESC_IDLE: begin
                        if (apb.pwdata[7:0] == CH_BSLASH) d.esc = ESC_SLASH;
                        else begin
                           d.tx_byte = apb.pwdata[7:0];
                           d.tx_valid = 1'b1;
                        end
                     end
                     ESC_SLASH: begin
                        if (apb.pwdata[7:0] == CH_X) d.esc = ESC_X;
                        else begin
                           // lone backslash goes out as itself, then the character
                           d.tx_byte = CH_BSLASH;
                           d.tx_valid = 1'b1;
                           d.pend = apb.pwdata[7:0];
                           d.pend_v = 1'b1;
                           d.esc = ESC_IDLE;
                        end
                     end
                     ESC_X: begin
                        d.esc_nib = hx[3:0];
                        d.esc = hx[4] ? ESC_HI : ESC_IDLE;
                     end
                     ESC_HI: begin
                        if (hx[4]) begin
                           d.tx_byte = {q.esc_nib, hx[3:0]};
                           d.tx_valid = 1'b1;
                        end
                        d.esc = ESC_IDLE;
                     end
                     default: d.esc = ESC_IDLE;
                  endcase
               end
            end
            default: ;
         endcase
      end

      // receive: first port wins if both enabled ports deliver in one cycle
      byte_v = 1'b0;
      rbyte = '0;
      if (rx_first.valid & q.on[0]) begin
         byte_v = 1'b1;
         rbyte = rx_first.data;
      end else if (rx_second.valid & q.on[1]) begin
         byte_v = 1'b1;
         rbyte = rx_second.data;
      end
      tail_n = {q.tail[SEP_BYTES*8-9:0], rbyte};
      cnt_n = (q.hold_cnt == HOLD_MAX) ? HOLD_MAX : q.hold_cnt + 1'b1;
      match = (q.sep_len != '0) && ({4'h0, q.sep_len} <= cnt_n);
      for (int i = 0; i < SEP_BYTES; i++) begin
         if (4'(i) < q.sep_len && tail_n[i*8 +: 8] != q.sep[i*8 +: 8]) match = 1'b0;
      end
      pub = 1'b0;
      plen = '0;
      pcap = q.cap;
      if (byte_v) begin
         d.tail = tail_n;
         d.hold_cnt = cnt_n;
         d.idle_cnt = '0;
         if (q.hold_cnt < HOLD_MAX) begin
            mem_we = 1'b1;
            mem_wdata = rbyte;
         end else begin
            ev[ST_OVFL] = 1'b1;
         end
         if (q.hold_cnt < 8'(CAP_BYTES)) pcap[q.hold_cnt*8 +: 8] = rbyte;
         d.cap = pcap;
         if (match) begin
            pub = 1'b1;
            plen = (cnt_n - 8'(q.sep_len) > 8'(CAP_BYTES)) ? CAP_MAX : 4'(cnt_n - 8'(q.sep_len));
         end
      end else if (tick && q.hold_cnt != '0 && q.idle_ms != '0) begin
         d.idle_cnt = q.idle_cnt + 1'b1;
         // idle set while bytes wait also closes them
         if (q.idle_cnt + 1'b1 >= q.idle_ms) begin
            pub = 1'b1;
            plen = (q.hold_cnt > 8'(CAP_BYTES)) ? CAP_MAX : q.hold_cnt[3:0];
         end
      end
      for (int i = 0; i < CAP_BYTES; i++) begin
         if (4'(i) >= plen) pcap[i*8 +: 8] = 8'h00;
      end

      if (q.fl_live) begin
         if (q.fl_cnt == '0) begin
            d.fl = '0;
            d.fl_len = '0;
            d.fl_dig = '0;
            d.fl_live = 1'b0;
            ev[ST_FLEET] = 1'b1;
         end else if (tick) begin
            d.fl_cnt = q.fl_cnt - 1'b1;
         end
      end

      if (pub) begin
         d.hold_cnt = '0;
         d.cap = '0;
         d.idle_cnt = '0;
         ev[ST_RECOG] = 1'b1;
         d.act_fire = 1'b1;
         d.act_out = q.act_num;
         d.last = pcap;
         d.last_len = plen;
         if (pcap != q.last || plen != q.last_len) ev[ST_PERS] = 1'b1;
         // empty fleeting copy means even a repeat counts as a change
         ev[ST_FLEET] = !q.fl_live || pcap != q.fl || plen != q.fl_len;
         d.fl = pcap;
         d.fl_len = plen;
         d.fl_dig = digest(pcap, plen);
         d.fl_cnt = q.fleet_ms;
         d.fl_live = 1'b1;
      end

      if (clr) begin
         d.last = '0;
         d.last_len = '0;
         d.fl = '0;
         d.fl_len = '0;
         d.fl_dig = '0;
         d.fl_live = 1'b0;
         d.hold_cnt = '0;
         d.cap = '0;
         d.idle_cnt = '0;
      end

      // a new event wins over the read that clears the status
      d.stat = (rd_clr ? '0 : q.stat) | ev;
      d.irq = |(d.stat & d.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.fleet_ms <= FLEET_RST_MS;
         q.esc <= ESC_IDLE;
      end else begin
         q <= d;
      end
   end

   smr_mem #(
      .W(8),
      .D(HOLD_BYTES),
      .AW(HOLD_AW)
   ) u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(hoff[HOLD_AW+1:2]),
      .rdata(mem_rdata)
   );

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx_byte = q.tx_byte;
   assign tx_valid = q.tx_valid;
   assign action = '{fire: q.act_fire, number: q.act_out};
   assign irq = q.irq;
endmodule // smr_recognizer

// File: tb/smr_recognizer_assertions.sv
// port-level checks of the serial message recognizer
`timescale 1ns/10ps
module smr_recognizer_assertions
   import smr_pkg::*;
#(
   parameter int unsigned MS_CYC = smr_pkg::MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input smr_pkg::smr_apb_s apb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input smr_pkg::smr_rx_s rx_first,
   input smr_pkg::smr_rx_s rx_second,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input smr_pkg::smr_action_s action,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // status, mask or control access may lower the interrupt
   wire logic st_acc = pready && (apb.paddr inside {OFS_STAT, OFS_MASK, OFS_CTRL});
   property p_ready_wait;
      apb.psel && !apb.penable |=> apb.penable ##1 pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
   property p_ready_access;
      pready |-> apb.psel && apb.penable && $past(apb.penable);
   endproperty
   a_ready_access: assert property (p_ready_access) else $error("pready outside access phase");
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error response malformed");
   property p_tx_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmit byte dropped before taken");
   property p_fire_twice;
      action.fire ##1 action.fire |-> $past(rx_first.valid || rx_second.valid);
   endproperty
   a_fire_twice: assert property (p_fire_twice) else $error("action fired without a byte");
   property p_reset_quiet;
      $rose(presetn) |-> !pready && !tx_valid && !action.fire && !irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
   property p_irq_fall;
      $fell(irq) |-> $past(st_acc) || $past(st_acc, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped on its own");
endmodule // smr_recognizer_assertions

bind smr_recognizer smr_recognizer_assertions #(.MS_CYC(MS_CYC)) i_smr_recognizer_assertions (.pclk(pclk),
   .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_first(rx_first),
   .rx_second(rx_second), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .action(action),
   .irq(irq));

// File: tb/smr_serial_model.sv
// far-side serial equipment: byte source on both ports, stalling byte sink
`timescale 1ns/10ps
module smr_serial_model
   import smr_pkg::*;
(
   input wire logic pclk,
   output smr_pkg::smr_rx_s rx_first,
   output smr_pkg::smr_rx_s rx_second,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] got[$];
   logic [1:0] cnt;
   initial begin
      rx_first = '0;
      rx_second = '0;
      tx_ready = 1'b0;
      cnt = 2'h0;
   end
   // back-to-back bytes; idle data inverted so a stale byte never looks valid
   task automatic send(input logic sec, input string s);
      foreach (s[i]) begin
         @(posedge pclk);
         rx_first <= '{~sec, sec ? ~rx_first.data : s[i]};
         rx_second <= '{sec, sec ? s[i] : ~rx_second.data};
      end
      @(posedge pclk);
      rx_first <= '{1'b0, ~rx_first.data};
      rx_second <= '{1'b0, ~rx_second.data};
   endtask
   // ready half the time, so the sender sees stalls
   always @(posedge pclk) begin
      if (tx_valid && tx_ready) got.push_back(tx_byte);
      cnt <= cnt + 2'h1;
      tx_ready <= cnt[1];
   end
endmodule // smr_serial_model

// File: tb/smr_recognizer_test.sv
// self-checking bench of the serial message recognizer
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module smr_recognizer_test;
   import smr_pkg::*;
   typedef struct {string msg; logic [11:0] addr; logic [31:0] exp;} smr_row_s;
   smr_row_s rows[6] = '{'{"Lo", OFS_LAST_LEN, 32'h2}, '{"Lo", OFS_LAST_TXT, 32'h6F4C},
      '{"Lo", OFS_LAST_HEX, 32'h46364334}, '{"Hi", OFS_FLEET_TXT, 32'h6948},
      '{"ABCDEFGHIJKLMN", OFS_LAST_TXT + 12'h8, 32'h4C4B4A49}, '{":", OFS_LAST_LEN, 32'h0}};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   smr_apb_s apb = '0;
   logic [31:0] prdata;
   logic [7:0] tx_byte;
   logic pready, pslverr, tx_valid, tx_ready, irq, erq;
   smr_rx_s rx_first, rx_second;
   smr_action_s action;
   int err_count = 0;
   int total_checks = 0;
   int fires = 0;
   logic [31:0] rd;
   string txt = "\\x0D";
   initial begin
      forever #20 pclk = ~pclk;
   end
   smr_recognizer #(.MS_CYC(10)) i_smr_recognizer (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_first(rx_first), .rx_second(rx_second), .tx_byte(tx_byte),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .action(action), .irq(irq));
   smr_serial_model i_smr_serial_model (.pclk(pclk), .rx_first(rx_first), .rx_second(rx_second),
      .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
   always @(posedge pclk) begin
      if (action.fire === 1'b1) begin
         fires++;
         `CHK(action.number, 8'h05)
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      apb <= '{1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      apb.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      erq = pslverr;
      if (n == 20) begin
         err_count++;
         final_report();
      end
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // poll busy; a stuck transmitter counts as a mismatch
   task automatic idle_tx();
      int n;
      n = 0;
      do begin
         xfer(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 50);
      `CHK(rd[0], 1'b0)
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(OFS_FLEET_T, 32'h32);
      rdc(OFS_CTRL, 32'h0);
      xfer(1'b1, OFS_ACTION, 32'h5);
      xfer(1'b1, OFS_SEP_LO, 32'h3A);
      xfer(1'b1, OFS_SEP_LEN, 32'h1);
      xfer(1'b1, OFS_MASK, 32'h1);
      xfer(1'b1, OFS_CTRL, 32'h1);
      foreach (rows[i]) begin
         i_smr_serial_model.send(1'b0, {rows[i].msg, ":"});
         rdc(rows[i].addr, rows[i].exp);
      end
      `CHK(fires, 7)
      `CHK(irq, 1'b1)
      rdc(OFS_STAT, 32'h7);
      @(posedge pclk);
      `CHK(irq, 1'b0)
      xfer(1'b1, OFS_FLEET_T, 32'h2);
      i_smr_serial_model.send(1'b0, "S1:");
      rdc(OFS_STAT, 32'h7);
      rdc(OFS_DIGEST, 32'h97);
      repeat (40) @(posedge pclk);
      rdc(OFS_FLEET_LEN, 32'h0);
      rdc(OFS_STAT, 32'h4);
      i_smr_serial_model.send(1'b0, "S1:");
      rdc(OFS_STAT, 32'h5);
      xfer(1'b1, OFS_CTRL, 32'h2);
      i_smr_serial_model.send(1'b0, "ZZ:");
      rdc(OFS_LAST_TXT, 32'h3153);
      i_smr_serial_model.send(1'b1, "Q:");
      rdc(OFS_LAST_TXT, 32'h51);
      xfer(1'b1, OFS_SEP_LO, 32'h0D0A);
      xfer(1'b1, OFS_SEP_LEN, 32'h2);
      i_smr_serial_model.send(1'b1, "A\015B\015\012");
      rdc(OFS_LAST_TXT, 32'h00420D41);
      // idle off: held bytes wait until a gap time is set
      i_smr_serial_model.send(1'b1, "HD");
      repeat (150) @(posedge pclk);
      rdc(OFS_LAST_TXT, 32'h00420D41);
      rdc(OFS_HOLD, 32'h48);
      rdc(OFS_STATUS, 32'h200);
      xfer(1'b1, OFS_IDLE, 32'h3);
      rdc(OFS_IDLE, 32'hA);
      repeat (120) @(posedge pclk);
      rdc(OFS_LAST_TXT, 32'h4448);
      xfer(1'b1, OFS_CTRL, 32'h102);
      rdc(OFS_LAST_LEN, 32'h0);
      rdc(12'h0F0, 32'h0);
      `CHK(erq, 1'b1)
      xfer(1'b1, OFS_TX_RAW, 32'h3433);
      idle_tx();
      foreach (txt[i]) begin
         xfer(1'b1, OFS_TX_TEXT, {24'h0, txt[i]});
         idle_tx();
      end
      `CHK(i_smr_serial_model.got[0], 8'h43)
      `CHK(i_smr_serial_model.got[1], 8'h0D)
      final_report();
   end
endmodule // smr_recognizer_test
